// *** hdl/irq_hold_ctrl.sv ***
// maskable interrupt flags, mask, vectoring and external bus-hold handshake
// Functional notes
// - readable sixteen-bit pending flag register
// - writing one clears flag, zero keeps
// - sixteen-bit mask enables interrupts when ungated
// - status bit nine gates all maskable interrupts
// - acknowledged interrupt loads its vector address
// - acknowledge output high during vector fetch
// - pins, peripherals and software raise interrupts
// - hold in service idle floats buses
// - grant low keeps bus lines released
// - hold ends on pin high or NMI
// - leaving idle restores normal bus drive
// - NMI ignores mask and global disable
// - control bit four selects shared request pin edge mode
// - only program counter saved and restored
`timescale 1ns/1ps
`default_nettype none
module irq_hold_ctrl
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // data-memory register port
    input  wire logic [15:0] dmem_addr,
    input  wire logic        dmem_wr,
    input  wire logic        dmem_rd,
    input  wire logic [15:0] dmem_wdata,
    output logic      [15:0] dmem_rdata,
    // status word zero from the core
    input  wire logic        status_word_zero_wr,
    input  wire logic [15:0] status_word_zero_wdata,
    output logic             global_irq_disable,
    // request sources
    input  wire logic        shared_request_pin_n,
    input  wire logic [1:0]  ext_irq_pins_n,
    input  wire logic        nmi_pin_n,
    input  wire logic [15:3] periph_irq,
    input  wire logic        soft_irq_instruction,
    input  wire logic [4:0]  soft_irq_num,
    // core sequencing
    input  wire logic        core_boundary,
    input  wire logic        idle_exec,
    input  wire logic        irq_return,
    output logic             irq_ack_out,
    output logic             vector_load,
    output logic      [15:0] vector_addr,
    output logic             pc_save,
    output logic             pc_restore,
    output logic             idle_exit,
    // external bus hold
    output logic             bus_grant_out_n,
    output logic             bus_release
);
    import irq_hold_pkg::*;

    ctl_state_t  state;
    ctl_state_t  next_state;
    logic [15:0] pending_flag_reg;
    logic [15:0] enable_mask_reg;
    logic        edge_mode;
    logic        nmi_pend;
    logic        soft_pend;
    logic [4:0]  soft_idx;
    logic        hold_isr;
    logic [3:0]  req_pulse;
    logic [3:0]  req_level_n;
    logic [3:0]  pin_vec_n;
    logic [3:0]  both_vec;
    logic [15:0] live;
    logic [3:0]  sel_idx;
    logic        masked_ok;
    logic        take;
    logic        take_mask;
    logic        hold_enter;
    logic        hold_leave;
    logic [15:0] clr_vec;
    wire  [15:0] set_vec = {periph_irq, req_pulse[2:0]};

    assign pin_vec_n = {nmi_pin_n, ext_irq_pins_n, shared_request_pin_n};
    assign both_vec  = {3'b000, edge_mode};

    for (genvar g = 0; g < 4; g++)
    begin : g_pin
        irq_edge_detect u_edge
        (
            .sys_clk    (sys_clk),
            .nrst       (nrst),
            .pin_n      (pin_vec_n[g]),
            .both_edges (both_vec[g]),
            .req        (req_pulse[g]),
            .level_n    (req_level_n[g])
        );
    end

    assign live      = pending_flag_reg & enable_mask_reg;
    assign sel_idx   = lowest_set(live);
    assign masked_ok = (|live) & ~global_irq_disable;
    // NMI and software requests bypass mask and gate
    assign take      = (state == ST_RUN) & core_boundary
                     & (nmi_pend | soft_pend | masked_ok);
    assign take_mask = take & ~nmi_pend & ~soft_pend;
    assign hold_enter = (state == ST_RUN) & ~take & idle_exec & hold_isr
                      & ~req_level_n[HOLD_FLAG];
    assign hold_leave = (state == ST_HOLD)
                      & (req_level_n[HOLD_FLAG] | req_pulse[3]);

    always_comb
    begin
        clr_vec = 16'h0000;
        if (dmem_wr && dmem_addr == ADDR_PENDING)
            clr_vec = dmem_wdata;
        if (take_mask)
            clr_vec[sel_idx] = 1'b1;
    end

    // a new request in the clearing cycle survives
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            pending_flag_reg <= PENDING_RESET;
        else
            pending_flag_reg <= (pending_flag_reg & ~clr_vec) | set_vec;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            enable_mask_reg <= ENABLE_RESET;
            edge_mode       <= MODE_RESET;
        end
        else if (dmem_wr)
        begin
            if (dmem_addr == ADDR_ENABLE)
                enable_mask_reg <= dmem_wdata;
            if (dmem_addr == ADDR_IRQ_CTRL)
                edge_mode <= dmem_wdata[MODE_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            dmem_rdata <= 16'h0000;
        else if (dmem_rd)
        begin
            case (dmem_addr)
                ADDR_PENDING:  dmem_rdata <= pending_flag_reg;
                ADDR_ENABLE:   dmem_rdata <= enable_mask_reg;
                ADDR_IRQ_CTRL: dmem_rdata <= 16'(edge_mode) << MODE_BIT;
                default:       dmem_rdata <= 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            global_irq_disable <= GDIS_RESET;
        else if (take_mask)
            global_irq_disable <= 1'b1;
        else if (status_word_zero_wr)
            global_irq_disable <= status_word_zero_wdata[GDIS_BIT];
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            nmi_pend  <= 1'b0;
            soft_pend <= 1'b0;
            soft_idx  <= 5'h00;
        end
        else
        begin
            nmi_pend <= req_pulse[3] | (nmi_pend & ~take);
            if (soft_irq_instruction)
            begin
                soft_pend <= 1'b1;
                soft_idx  <= soft_irq_num;
            end
            else if (take && !nmi_pend)
                soft_pend <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            vector_addr <= 16'h0000;
            hold_isr    <= 1'b0;
        end
        else if (take)
        begin
            if (nmi_pend)
                vector_addr <= NMI_VEC;
            else if (soft_pend)
                vector_addr <= vec_of(soft_idx);
            else
                vector_addr <= vec_of({1'b0, sel_idx});
            hold_isr <= take_mask && sel_idx == 4'(HOLD_FLAG);
        end
        else if (irq_return)
            hold_isr <= 1'b0;
    end

    always_comb
    begin
        next_state = state;
        case (state)
            ST_RUN:
            begin
                if (take)
                    next_state = ST_ACK;
                else if (hold_enter)
                    next_state = ST_HOLD;
            end
            ST_ACK:  next_state = ST_RUN;
            ST_HOLD:
            begin
                if (hold_leave)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            state <= ST_RUN;
        else
            state <= next_state;
    end

    // bus drive follows the state register so grant and release never split
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_grant_out_n <= 1'b1;
            bus_release     <= 1'b0;
            idle_exit       <= 1'b0;
            pc_restore      <= 1'b0;
        end
        else
        begin
            bus_grant_out_n <= ~(next_state == ST_HOLD);
            bus_release     <= next_state == ST_HOLD;
            idle_exit       <= hold_leave;
            pc_restore      <= irq_return;
        end
    end

    assign irq_ack_out = state == ST_ACK;
    assign vector_load = state == ST_ACK;
    assign pc_save     = state == ST_ACK;

    w1c_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        dmem_wr && dmem_addr == ADDR_PENDING && dmem_wdata[5] && !periph_irq[5]
        |=> !pending_flag_reg[5])
        else $error("pending flag not cleared by one");
    zero_keeps_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (|($past(pending_flag_reg) & ~pending_flag_reg & ~$past(clr_vec))) == 1'b0)
        else $error("pending flag lost without clear");
    gate_blocks_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state == ST_RUN && global_irq_disable && !nmi_pend && !soft_pend
        |=> !irq_ack_out)
        else $error("maskable taken while gated");
    mask_takes_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state == ST_RUN && core_boundary && !global_irq_disable && (|live)
        |=> irq_ack_out ##1 !irq_ack_out)
        else $error("enabled interrupt not acknowledged");
    vector_lowest_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        take_mask && !set_vec[sel_idx] |=> vector_addr == vec_of({1'b0, $past(sel_idx)})
        && !pending_flag_reg[$past(sel_idx)] && global_irq_disable)
        else $error("wrong vector or flag kept");
    ack_fetch_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        irq_ack_out |-> vector_load && pc_save && !bus_release)
        else $error("acknowledge without vector fetch");
    nmi_unmasked_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        nmi_pend && state == ST_RUN && core_boundary
        |=> irq_ack_out && vector_addr == NMI_VEC)
        else $error("nmi not taken");
    grant_release_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        bus_grant_out_n == !bus_release)
        else $error("grant and release disagree");
    hold_exit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state == ST_HOLD && req_level_n[HOLD_FLAG]
        |=> bus_grant_out_n && idle_exit && state == ST_RUN)
        else $error("hold not ended on release");

endmodule : irq_hold_ctrl
`default_nettype wire

// *** inc/irq_hold_pkg.sv ***
// constants, types and helpers for the interrupt and bus-hold logic
package irq_hold_pkg;

    localparam int          FLAG_W         = 16;
    // data-memory addresses of the mapped registers
    localparam logic [15:0] ADDR_ENABLE    = 16'h0004;
    localparam logic [15:0] ADDR_PENDING   = 16'h0006;
    localparam logic [15:0] ADDR_IRQ_CTRL  = 16'h0007;
    // field positions
    localparam int          GDIS_BIT       = 9;
    localparam int          MODE_BIT       = 4;
    localparam int          HOLD_FLAG      = 0;
    // reset values
    localparam logic [15:0] ENABLE_RESET   = 16'h0000;
    localparam logic [15:0] PENDING_RESET  = 16'h0000;
    localparam logic        MODE_RESET     = 1'b0;
    localparam logic        GDIS_RESET     = 1'b1;
    // program-memory vector table
    localparam logic [15:0] VEC_BASE       = 16'h0002;
    localparam logic [15:0] NMI_VEC        = 16'h0024;

    typedef enum logic [2:0]
    {
        ST_RUN  = 3'b001,
        ST_ACK  = 3'b010,
        ST_HOLD = 3'b100
    } ctl_state_t;

    // index of the lowest set bit, zero when none
    function automatic logic [3:0] lowest_set(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--)
        begin
            if (v[i])
                r = i[3:0];
        end
        return r;
    endfunction : lowest_set

    // two words per vector slot
    function automatic logic [15:0] vec_of(input logic [4:0] idx);
        return VEC_BASE + {10'h000, idx, 1'b0};
    endfunction : vec_of

endpackage : irq_hold_pkg

// *** hdl/irq_edge_detect.sv ***
// pin synchroniser with falling or both-edge request detection
`timescale 1ns/1ps
`default_nettype none
module irq_edge_detect
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // pin side
    input  wire logic pin_n,
    input  wire logic both_edges,
    // logic side
    output logic      req,
    output logic      level_n
);
    logic meta_n;
    logic prev_n;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_n  <= 1'b1;
            level_n <= 1'b1;
            prev_n  <= 1'b1;
        end
        else
        begin
            meta_n  <= pin_n;
            level_n <= meta_n;
            prev_n  <= level_n;
        end
    end

    assign req = (prev_n & ~level_n) | (both_edges & ~prev_n & level_n);

endmodule : irq_edge_detect
`default_nettype wire

// *** testbench/bus_master_model.sv ***
// outside bus master that asks for the buses on the shared pin
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // bench command
    input  wire logic want_bus,
    // device pin
    output logic      shared_request_pin_n
);
    // pin is pulled high whenever no request stands
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            shared_request_pin_n <= 1'b1;
        else
            shared_request_pin_n <= !want_bus;
    end
endmodule : bus_master_model
`default_nettype wire

// *** testbench/test_irq_hold_ctrl.sv ***
// self-checking bench for the interrupt and bus-hold block
`timescale 1ns/1ps
`default_nettype none
module test_irq_hold_ctrl;
    import irq_hold_pkg::*;
    logic        sys_clk, nrst, dmem_wr, dmem_rd, nmi_pin_n, want_bus, rd_pend;
    logic        status_word_zero_wr;
    logic [15:0] status_word_zero_wdata;
    logic        soft_irq_instruction, core_boundary, idle_exec, irq_return, irq_ack_out;
    logic        global_irq_disable, shared_request_pin_n, vector_load, pc_save;
    logic        pc_restore, idle_exit, bus_grant_out_n, bus_release;
    logic [15:0] dmem_addr, dmem_wdata, dmem_rdata, vector_addr, p;
    logic [15:3] periph_irq;
    logic [4:0]  soft_irq_num;
    logic [1:0]  ext_irq_pins_n;
    logic [16:0] e;
    logic [16:0] exp_q[$];
    logic [31:0] lfsr;
    int          err_count, n_checks;

    irq_hold_ctrl irq_hold_ctrl_i
    (
        .sys_clk, .nrst, .dmem_addr, .dmem_wr, .dmem_rd, .dmem_wdata, .dmem_rdata,
        .status_word_zero_wr, .status_word_zero_wdata, .global_irq_disable,
        .shared_request_pin_n,
        .ext_irq_pins_n, .nmi_pin_n, .periph_irq, .soft_irq_instruction, .soft_irq_num,
        .core_boundary, .idle_exec, .irq_return, .irq_ack_out, .vector_load,
        .vector_addr, .pc_save, .pc_restore, .idle_exit, .bus_grant_out_n, .bus_release
    );
    bus_master_model bus_master_model_i
    (
        .sys_clk, .nrst, .want_bus, .shared_request_pin_n
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        dmem_addr  <= a;
        dmem_wdata <= d;
        dmem_wr    <= 1'b1;
        @(posedge sys_clk);
        dmem_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] x);
        exp_q.push_back({1'b0, x});
        @(posedge sys_clk);
        dmem_addr <= a;
        dmem_rd   <= 1'b1;
        @(posedge sys_clk);
        dmem_rd   <= 1'b0;
        @(posedge sys_clk);
    endtask : rd

    task automatic st0w(input logic [15:0] d);
        @(posedge sys_clk);
        status_word_zero_wdata <= d;
        status_word_zero_wr    <= 1'b1;
        @(posedge sys_clk);
        status_word_zero_wr    <= 1'b0;
    endtask : st0w

    task automatic pulse(input logic [15:0] v);
        @(posedge sys_clk);
        periph_irq <= v[15:3];
        @(posedge sys_clk);
        periph_irq <= '0;
    endtask : pulse

    // bounded wait; a vector that never comes counts as a mismatch
    task automatic wait_ack(input logic [15:0] v);
        exp_q.push_back({1'b1, v});
        repeat (20)
            if (exp_q.size() != 0)
                @(negedge sys_clk);
        if (exp_q.size() != 0)
            chk(17'h0_0000, exp_q.pop_front());
    endtask : wait_ack

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // an acknowledge with no note waiting is flagged as well
    always @(negedge sys_clk)
    begin
        if (rd_pend || irq_ack_out === 1'b1)
        begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 17'h1_ffff;
            chk(rd_pend ? {1'b0, dmem_rdata} : {1'b1, vector_addr}, e);
        end
        if (irq_ack_out === 1'b1)
            chk({15'h0000, pc_save, vector_load}, 17'h0_0003);
        rd_pend = (dmem_rd === 1'b1);
    end

    initial
    begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        summarize();
    end

    initial
    begin
        {dmem_wr, dmem_rd, status_word_zero_wr, soft_irq_instruction, idle_exec} = '0;
        {irq_return, want_bus, rd_pend, nrst, core_boundary} = '0;
        {dmem_addr, dmem_wdata, status_word_zero_wdata, periph_irq, soft_irq_num} = '0;
        {ext_irq_pins_n, nmi_pin_n} = 3'b111;
        err_count = 0;
        n_checks = 0;
        lfsr = 32'hdab3_260a;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        core_boundary <= 1'b1;
        @(negedge sys_clk);
        chk({16'h0000, global_irq_disable}, 17'h0_0001);
        rd(ADDR_PENDING, 16'h0000);
        rd(16'h0005, 16'h0000);
        lfsr = next_rand(lfsr);
        wr(ADDR_ENABLE, lfsr[15:0]);
        rd(ADDR_ENABLE, lfsr[15:0]);
        p = {lfsr[31:19], 3'b000};
        pulse(p);
        rd(ADDR_PENDING, p);
        wr(ADDR_PENDING, lfsr[15:0]);
        p = p & ~lfsr[15:0];
        rd(ADDR_PENDING, p);
        ext_irq_pins_n <= 2'b00;
        repeat (4) @(posedge sys_clk);
        rd(ADDR_PENDING, p | 16'h0006);
        ext_irq_pins_n <= 2'b11;
        wr(ADDR_PENDING, 16'hffff);
        // falling edge only, then both edges
        want_bus <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rd(ADDR_PENDING, 16'h0001);
        wr(ADDR_PENDING, 16'hffff);
        want_bus <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rd(ADDR_PENDING, 16'h0000);
        want_bus <= 1'b1;
        wr(ADDR_IRQ_CTRL, 16'h0010);
        rd(ADDR_IRQ_CTRL, 16'h0010);
        repeat (5) @(posedge sys_clk);
        wr(ADDR_PENDING, 16'hffff);
        want_bus <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rd(ADDR_PENDING, 16'h0001);
        wr(ADDR_IRQ_CTRL, 16'h0000);
        wr(ADDR_PENDING, 16'hffff);
        // each take must pick the lowest flag and close the gate again
        wr(ADDR_ENABLE, 16'hffff);
        lfsr = next_rand(lfsr);
        p = {lfsr[15:3], 3'b000};
        pulse(p);
        for (int i = 3; i < 16; i++)
        begin
            if (p[i])
            begin
                st0w(16'h0000);
                wait_ack(VEC_BASE + {11'h000, i[3:0], 1'b0});
                chk({16'h0000, global_irq_disable}, 17'h0_0001);
            end
        end
        rd(ADDR_PENDING, 16'h0000);
        pulse(16'h0008);
        repeat (8) @(posedge sys_clk);
        rd(ADDR_PENDING, 16'h0008);
        wr(ADDR_PENDING, 16'hffff);
        nmi_pin_n <= 1'b0;
        wait_ack(NMI_VEC);
        @(posedge sys_clk);
        nmi_pin_n <= 1'b1;
        repeat (3)
        begin
            lfsr = next_rand(lfsr);
            @(posedge sys_clk);
            soft_irq_instruction <= 1'b1;
            soft_irq_num <= lfsr[4:0];
            @(posedge sys_clk);
            soft_irq_instruction <= 1'b0;
            wait_ack(VEC_BASE + {10'h000, lfsr[4:0], 1'b0});
        end
        // hold handshake through the shared pin
        wr(ADDR_ENABLE, 16'h0001);
        want_bus <= 1'b1;
        repeat (5) @(posedge sys_clk);
        st0w(16'h0000);
        wait_ack(VEC_BASE);
        @(posedge sys_clk);
        idle_exec <= 1'b1;
        @(posedge sys_clk);
        idle_exec <= 1'b0;
        @(negedge sys_clk);
        chk({15'h0000, bus_grant_out_n, bus_release}, 17'h0_0001);
        @(posedge sys_clk);
        want_bus <= 1'b0;
        repeat (10)
            if (bus_grant_out_n !== 1'b1)
                @(negedge sys_clk);
        chk({15'h0000, idle_exit, bus_release}, 17'h0_0002);
        // second hold, ended by a nonmaskable request instead of the pin
        @(posedge sys_clk);
        want_bus <= 1'b1;
        repeat (5) @(posedge sys_clk);
        idle_exec <= 1'b1;
        @(posedge sys_clk);
        idle_exec <= 1'b0;
        @(negedge sys_clk);
        chk({15'h0000, bus_grant_out_n, bus_release}, 17'h0_0001);
        @(posedge sys_clk);
        nmi_pin_n <= 1'b0;
        wait_ack(NMI_VEC);
        chk({15'h0000, bus_grant_out_n, bus_release}, 17'h0_0002);
        @(posedge sys_clk);
        nmi_pin_n <= 1'b1;
        irq_return <= 1'b1;
        @(posedge sys_clk);
        irq_return <= 1'b0;
        idle_exec <= 1'b1;
        @(negedge sys_clk);
        chk({16'h0000, pc_restore}, 17'h0_0001);
        @(posedge sys_clk);
        idle_exec <= 1'b0;
        @(negedge sys_clk);
        chk({15'h0000, bus_grant_out_n, bus_release}, 17'h0_0002);
        summarize();
    end
endmodule : test_irq_hold_ctrl
`default_nettype wire
